// ===== inc/pbtc_cfg.svh
// register offsets, field positions, count and read constants and steps of the block transfer controller
`ifndef PBTC_CFG_SVH
`define PBTC_CFG_SVH
`define PBTC_OFS_CTRL 4'h0
`define PBTC_OFS_PTR 4'h4
`define PBTC_OFS_CNT 4'h8
`define PBTC_OFS_PADDR 4'hc
`define PBTC_CH_LSB 4
`define PBTC_CH_MSB 7
`define PBTC_CTRL_DIR 0
`define PBTC_CTRL_SZ_LO 1
`define PBTC_CTRL_SZ_HI 2
`define PBTC_CNT_W 16
`define PBTC_CNT_ONE 16'h0001
`define PBTC_CNT_ZERO 16'h0000
`define PBTC_INC_BYTE 32'h00000001
`define PBTC_INC_HALF 32'h00000002
`define PBTC_INC_WORD 32'h00000004
`define PBTC_HSIZE_WORD 3'h2
`define PBTC_RD_ZERO 32'h00000000
`endif

// ===== inc/pbtc_pkg.sv
// types shared by the block transfer controller modules
`include "pbtc_cfg.svh"
package pbtc_pkg;
    typedef enum logic [1:0] {
        PBTC_SZ_BYTE = 2'h0,
        PBTC_SZ_HALF = 2'h1,
        PBTC_SZ_WORD = 2'h2
    } pbtc_size_t;
    typedef enum logic [4:0] {
        MV_IDLE = 5'h01,
        MV_SREQ = 5'h02,
        MV_MEM = 5'h04,
        MV_PREQ = 5'h08,
        MV_PER = 5'h10
    } pbtc_mv_st_t;
    typedef struct packed {
        logic dir;
        pbtc_size_t size;
        logic [31:0] ptr;
        logic [`PBTC_CNT_W-1:0] cnt;
        logic [31:0] paddr;
        logic pend;
    } pbtc_chan_t;
endpackage

// ===== inc/pbtc_mv_if.sv
// element move request between channel engine and bus mover
`timescale 1ns/1ns
interface pbtc_mv_if;
    logic start;
    logic dir;
    pbtc_pkg::pbtc_size_t size;
    logic [31:0] maddr;
    logic [31:0] paddr;
    logic done;
    modport eng (output start, output dir, output size, output maddr, output paddr, input done);
    modport mov (input start, input dir, input size, input maddr, input paddr, output done);
endinterface

// ===== verilog/pbtc_mover.sv
// moves one element between memory and peripheral over the two buses
`timescale 1ns/1ns
module pbtc_mover
(
    input wire logic clk,
    input wire logic srst,
    pbtc_mv_if.mov mv,
    output logic sys_req,
    input wire logic sys_gnt,
    output logic mem_valid,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ready,
    output logic per_req,
    input wire logic per_gnt,
    output logic per_valid,
    output logic per_write,
    output logic [31:0] per_addr,
    output logic [31:0] per_wdata,
    input wire logic [31:0] per_rdata,
    input wire logic per_ready,
    output logic [1:0] xfer_size
);
    typedef struct packed {
        pbtc_pkg::pbtc_mv_st_t st;
        logic sreq;
        logic mvalid;
        logic mwrite;
        logic preq;
        logic pvalid;
        logic pwrite;
        logic [31:0] data;
        logic done;
    } pbtc_mv_reg_t;

    pbtc_mv_reg_t r_reg;
    pbtc_mv_reg_t r_next;

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_comb
    begin
        r_next = r_reg;
        r_next.done = 1'b0;
        case (r_reg.st)
            pbtc_pkg::MV_IDLE:
                if (mv.start)
                begin
                    if (mv.dir)
                    begin
                        r_next.st = pbtc_pkg::MV_SREQ;
                        r_next.sreq = 1'b1;
                    end
                    else
                    begin
                        r_next.st = pbtc_pkg::MV_PREQ;
                        r_next.preq = 1'b1;
                    end
                end
            pbtc_pkg::MV_SREQ:
                if (sys_gnt)
                begin
                    r_next.st = pbtc_pkg::MV_MEM;
                    r_next.mvalid = 1'b1;
                    r_next.mwrite = !mv.dir;
                end
            pbtc_pkg::MV_MEM:
                if (mem_ready)
                begin
                    r_next.mvalid = 1'b0;
                    r_next.sreq = 1'b0;
                    if (mv.dir)
                    begin
                        r_next.data = mem_rdata;
                        r_next.st = pbtc_pkg::MV_PREQ;
                        r_next.preq = 1'b1;
                    end
                    else
                    begin
                        r_next.st = pbtc_pkg::MV_IDLE;
                        r_next.done = 1'b1;
                    end
                end
            pbtc_pkg::MV_PREQ:
                if (per_gnt)
                begin
                    r_next.st = pbtc_pkg::MV_PER;
                    r_next.pvalid = 1'b1;
                    r_next.pwrite = mv.dir;
                end
            pbtc_pkg::MV_PER:
                if (per_ready)
                begin
                    r_next.pvalid = 1'b0;
                    r_next.preq = 1'b0;
                    if (mv.dir)
                    begin
                        r_next.st = pbtc_pkg::MV_IDLE;
                        r_next.done = 1'b1;
                    end
                    else
                    begin
                        r_next.data = per_rdata;
                        r_next.st = pbtc_pkg::MV_SREQ;
                        r_next.sreq = 1'b1;
                    end
                end
            default:
                r_next.st = pbtc_pkg::MV_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r_reg <= '0;
            r_reg.st <= pbtc_pkg::MV_IDLE;
        end
        else
            r_reg <= r_next;
    end

    assign mv.done = r_reg.done;
    assign sys_req = r_reg.sreq;
    assign mem_valid = r_reg.mvalid;
    assign mem_write = r_reg.mwrite;
    assign mem_addr = mv.maddr;
    assign mem_wdata = r_reg.data;
    assign per_req = r_reg.preq;
    assign per_valid = r_reg.pvalid;
    assign per_write = r_reg.pwrite;
    assign per_addr = mv.paddr;
    assign per_wdata = r_reg.data;
    assign xfer_size = mv.size;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence done_quiet;
        !mv.done [*2];
    endsequence

    chk_grant_first: assert property ($rose(mem_valid) |-> $past(sys_gnt) && sys_req)
        else $error("memory access without grant");
    chk_bus_release: assert property (mem_valid && mem_ready |=> !sys_req && !mem_valid)
        else $error("system bus held after element");
    chk_per_bridge: assert property (per_valid |-> !sys_req)
        else $error("system bus held during peripheral access");
    chk_single_move: assert property (mv.done |=> done_quiet)
        else $error("moves chained");
endmodule

// ===== verilog/pbtc_top.sv
// ten channel peripheral block transfer controller with AHB-Lite register slave
// ----------------------------------------
// How it works
// - each channel moves a block between memory and its peripheral unaided.
// - system bus requested, grant awaited, before each memory access.
// - peripheral access goes over peripheral bus after its own arbitration.
// - channels 0..9 each have control, pointer and count registers.
// - each finished element decrements count and advances pointer.
// - count reaching zero pulses end so the peripheral sets its flag.
// - byte, half-word or word elements in either direction.
// - one element per peripheral request; no self chaining.
// - system bus request dropped after every element.
// - blocks programmable up to 65535 elements.
// - zero count stops the channel and ignores requests.
// - 32-bit memory pointer per channel.
// - pointer steps 1, 2 or 4 by element size.
// - pointer rewritten mid-block is used and advanced from.
// - 16-bit count, readable; requests accepted only while nonzero.
// - count rewritten mid-block continues from the new value.
// - end shown on a dedicated end signal; no own status register.
// - direction bit 0 receives, 1 transmits.
// ----------------------------------------
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`include "pbtc_cfg.svh"
module pbtc_top
#(
    parameter int NCH = 10
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic block_enable,
    input wire logic [NCH-1:0] chan_request,
    output logic [NCH-1:0] block_end_signal,
    output logic sys_req,
    input wire logic sys_gnt,
    output logic mem_valid,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ready,
    output logic per_req,
    input wire logic per_gnt,
    output logic per_valid,
    output logic per_write,
    output logic [31:0] per_addr,
    output logic [31:0] per_wdata,
    input wire logic [31:0] per_rdata,
    input wire logic per_ready,
    output logic [1:0] xfer_size
);
    typedef struct packed {
        pbtc_pkg::pbtc_chan_t [NCH-1:0] ch;
        logic busy;
        logic [3:0] cur;
        logic wr_ptr;
        logic wr_cnt;
        logic [NCH-1:0] ends;
        logic start;
        logic dir;
        pbtc_pkg::pbtc_size_t size;
        logic [31:0] maddr;
        logic [31:0] paddr;
        logic ap_valid;
        logic ap_write;
        logic ap_word;
        logic [7:0] ap_addr;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
    } pbtc_top_st_t;

    pbtc_top_st_t st_reg;
    pbtc_top_st_t st_next;
    pbtc_mv_if mv();
    logic [3:0] ap_ch;
    logic ap_hit;
    logic wr_en;
    logic [NCH-1:0] ready_vec;
    logic [`PBTC_CNT_W-1:0] cur_cnt;
    logic [31:0] cur_ptr;
    logic [31:0] cur_step;
    logic [3:0] pick;
    logic any;
    logic [31:0] rd_word;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] step_of(input pbtc_pkg::pbtc_size_t s);
        case (s)
            pbtc_pkg::PBTC_SZ_HALF: step_of = `PBTC_INC_HALF;
            pbtc_pkg::PBTC_SZ_WORD: step_of = `PBTC_INC_WORD;
            default: step_of = `PBTC_INC_BYTE;
        endcase
    endfunction

    function automatic pbtc_pkg::pbtc_size_t size_of(input logic [1:0] f);
        case (f)
            pbtc_pkg::PBTC_SZ_HALF: size_of = pbtc_pkg::PBTC_SZ_HALF;
            pbtc_pkg::PBTC_SZ_WORD: size_of = pbtc_pkg::PBTC_SZ_WORD;
            default: size_of = pbtc_pkg::PBTC_SZ_BYTE;
        endcase
    endfunction

    assign ap_ch = st_reg.ap_addr[`PBTC_CH_MSB:`PBTC_CH_LSB];
    assign ap_hit = (ap_ch < NCH);
    assign wr_en = st_reg.ap_valid && st_reg.ap_write && st_reg.ap_word && ap_hit;
    assign cur_cnt = st_reg.ch[st_reg.cur].cnt;
    assign cur_ptr = st_reg.ch[st_reg.cur].ptr;
    assign cur_step = step_of(st_reg.size);

    // channel armed only with pending request and nonzero count
    for (genvar g = 0; g < NCH; g++)
    begin : g_rdy
        assign ready_vec[g] = st_reg.ch[g].pend && (st_reg.ch[g].cnt != `PBTC_CNT_ZERO);
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        st_next = st_reg;
        pick = 4'h0;
        any = 1'b0;
        rd_word = `PBTC_RD_ZERO;
        st_next.start = 1'b0;
        st_next.ends = '0;
        st_next.hready = 1'b1;
        st_next.hresp = 1'b0;
        st_next.ap_valid = 1'b0;

        // element finished
        if (mv.done)
        begin
            st_next.busy = 1'b0;
            if (!st_reg.wr_ptr)
                st_next.ch[st_reg.cur].ptr = cur_ptr + cur_step;
            if (!st_reg.wr_cnt && cur_cnt != `PBTC_CNT_ZERO)
            begin
                st_next.ch[st_reg.cur].cnt = cur_cnt - `PBTC_CNT_ONE;
                if (cur_cnt == `PBTC_CNT_ONE)
                begin
                    st_next.ends[st_reg.cur] = 1'b1;
                    st_next.ch[st_reg.cur].pend = 1'b0;
                end
            end
        end

        // lowest armed channel wins
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (ready_vec[i])
            begin
                pick = 4'(i);
                any = 1'b1;
            end
        end
        if (!st_reg.busy && block_enable && any)
        begin
            st_next.busy = 1'b1;
            st_next.start = 1'b1;
            st_next.cur = pick;
            st_next.wr_ptr = 1'b0;
            st_next.wr_cnt = 1'b0;
            st_next.ch[pick].pend = 1'b0;
            st_next.dir = st_reg.ch[pick].dir;
            st_next.size = st_reg.ch[pick].size;
            st_next.maddr = st_reg.ch[pick].ptr;
            st_next.paddr = st_reg.ch[pick].paddr;
        end

        // register writes
        if (wr_en)
        begin
            case (st_reg.ap_addr[3:0])
                `PBTC_OFS_CTRL:
                begin
                    st_next.ch[ap_ch].dir = hwdata[`PBTC_CTRL_DIR];
                    st_next.ch[ap_ch].size = size_of(hwdata[`PBTC_CTRL_SZ_HI:`PBTC_CTRL_SZ_LO]);
                end
                `PBTC_OFS_PTR:
                begin
                    st_next.ch[ap_ch].ptr = hwdata;
                    if (st_next.busy && ap_ch == st_next.cur)
                        st_next.wr_ptr = 1'b1;
                end
                `PBTC_OFS_CNT:
                begin
                    st_next.ch[ap_ch].cnt = hwdata[`PBTC_CNT_W-1:0];
                    if (hwdata[`PBTC_CNT_W-1:0] == `PBTC_CNT_ZERO)
                        st_next.ch[ap_ch].pend = 1'b0;
                    if (st_next.busy && ap_ch == st_next.cur)
                        st_next.wr_cnt = 1'b1;
                end
                `PBTC_OFS_PADDR:
                    st_next.ch[ap_ch].paddr = hwdata;
                default:
                    st_next.ap_valid = 1'b0;
            endcase
        end

        // register reads
        if (ap_hit)
        begin
            case (st_reg.ap_addr[3:0])
                `PBTC_OFS_CTRL:
                    rd_word = {29'h0, st_reg.ch[ap_ch].size, st_reg.ch[ap_ch].dir};
                `PBTC_OFS_PTR:
                    rd_word = st_reg.ch[ap_ch].ptr;
                `PBTC_OFS_CNT:
                    rd_word = {16'h0, st_reg.ch[ap_ch].cnt};
                `PBTC_OFS_PADDR:
                    rd_word = st_reg.ch[ap_ch].paddr;
                default:
                    rd_word = `PBTC_RD_ZERO;
            endcase
        end
        if (st_reg.ap_valid && !st_reg.ap_write)
            st_next.hrdata = rd_word;

        // peripheral requests, set wins over clear
        for (int i = 0; i < NCH; i++)
        begin
            if (chan_request[i] && st_next.ch[i].cnt != `PBTC_CNT_ZERO)
                st_next.ch[i].pend = 1'b1;
        end

        // address phase capture
        if (hsel && hready && htrans[1])
        begin
            st_next.ap_valid = 1'b1;
            st_next.ap_write = hwrite;
            st_next.ap_word = (hsize == `PBTC_HSIZE_WORD);
            st_next.ap_addr = haddr[7:0];
            st_next.hready = hwrite;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg <= '0;
            st_reg.hready <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // ----------------------------------------
    // outputs and mover
    // ----------------------------------------
    assign hreadyout = st_reg.hready;
    assign hresp = st_reg.hresp;
    assign hrdata = st_reg.hrdata;
    assign block_end_signal = st_reg.ends;
    assign mv.start = st_reg.start;
    assign mv.dir = st_reg.dir;
    assign mv.size = st_reg.size;
    assign mv.maddr = st_reg.maddr;
    assign mv.paddr = st_reg.paddr;

    pbtc_mover u_mover
    (
        .clk(clk),
        .srst(srst),
        .mv(mv.mov),
        .sys_req(sys_req),
        .sys_gnt(sys_gnt),
        .mem_valid(mem_valid),
        .mem_write(mem_write),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .mem_ready(mem_ready),
        .per_req(per_req),
        .per_gnt(per_gnt),
        .per_valid(per_valid),
        .per_write(per_write),
        .per_addr(per_addr),
        .per_wdata(per_wdata),
        .per_rdata(per_rdata),
        .per_ready(per_ready),
        .xfer_size(xfer_size)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence read_taken;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence end_once;
        (block_end_signal != '0) ##1 (block_end_signal == '0);
    endsequence

    chk_read_wait: assert property (read_taken |=> one_wait)
        else $error("read wait state wrong");
    chk_count_step: assert property (mv.done && !st_reg.wr_cnt && !wr_en
        && cur_cnt != `PBTC_CNT_ZERO |=> cur_cnt == $past(cur_cnt) - `PBTC_CNT_ONE)
        else $error("count not decremented");
    chk_ptr_step: assert property (mv.done && !st_reg.wr_ptr && !wr_en
        |=> cur_ptr == $past(cur_ptr) + $past(cur_step))
        else $error("pointer step wrong");
    chk_end_pulse: assert property (mv.done && !st_reg.wr_cnt && !wr_en
        && cur_cnt == `PBTC_CNT_ONE |=> end_once)
        else $error("end pulse missing");
    chk_end_cause: assert property ((block_end_signal != '0) |-> $past(mv.done))
        else $error("end pulse without element");
    chk_one_at_time: assert property (mv.start |-> !$past(st_reg.busy) && st_reg.busy)
        else $error("overlapping elements");

    sequence write_taken;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    chk_write_nowait: assert property (write_taken |=> hreadyout)
        else $error("write wait state inserted");
    chk_zero_idle: assert property (mv.start && !$past(wr_en) |-> cur_cnt != `PBTC_CNT_ZERO)
        else $error("channel with zero count started");
endmodule

// ===== sim/pbtc_partner.sv
// arbiter, memory and peripheral model at the far side of the block transfer controller
`timescale 1ns/1ns
module pbtc_partner
(
    input wire logic clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic sys_req,
    output logic sys_gnt,
    input wire logic mem_valid,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ready,
    input wire logic per_req,
    output logic per_gnt,
    input wire logic per_valid,
    input wire logic per_write,
    input wire logic [31:0] per_addr,
    input wire logic [31:0] per_wdata,
    output logic [31:0] per_rdata,
    output logic per_ready,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [7:0] n_done
);
    logic [1:0] dly;
    logic go;
    logic mr;
    logic pr;
    assign go = !slow || dly == 2'h3;
    assign mr = mem_valid & ~mem_ready & go;
    assign pr = per_valid & ~per_ready & go;
    // ----------------------------------------
    // grants, answers and write log
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            {dly, sys_gnt, per_gnt, mem_ready, per_ready} <= '0;
            {mem_rdata, per_rdata, wr_addr, wr_data, n_done} <= '0;
        end
        else
        begin
            dly <= (mr | pr) ? 2'h0 : dly + {1'b0, dly != 2'h3};
            sys_gnt <= sys_req & (sys_gnt | go);
            per_gnt <= per_req & (per_gnt | go);
            mem_ready <= mr;
            per_ready <= pr;
            // released data lines show the inverse of the last value
            mem_rdata <= mr ? (~mem_addr ^ 32'h5a000000) : ~mem_rdata;
            per_rdata <= pr ? {per_addr[15:0], 16'h3c00} : ~per_rdata;
            if (mem_ready & mem_valid & mem_write)
            begin
                wr_addr <= mem_addr;
                wr_data <= mem_wdata;
                n_done <= n_done + 8'h01;
            end
            if (per_ready & per_valid & per_write)
            begin
                wr_addr <= per_addr;
                wr_data <= per_wdata;
                n_done <= n_done + 8'h01;
            end
        end
    end
endmodule

// ===== sim/pbtc_top_tb.sv
// self-checking testbench of the block transfer controller
`timescale 1ns/1ns
`include "pbtc_cfg.svh"
module pbtc_top_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, block_enable = 1'b1, slow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [9:0] chan_request = 10'h000;
    logic hready, hreadyout, hresp, sys_req, sys_gnt, mem_valid, mem_write, mem_ready;
    logic per_req, per_gnt, per_valid, per_write, per_ready, sreq_d = 1'b0;
    logic [31:0] hrdata, mem_addr, mem_wdata, mem_rdata, per_addr, per_wdata, per_rdata;
    logic [31:0] wr_addr, wr_data, r;
    logic [9:0] block_end_signal, last_end = 10'h000;
    logic [1:0] xfer_size;
    logic [7:0] n_done, n0, n_end = 8'h00, e0, n_sreq = 8'h00, s0;
    int num_errors = 0, n_checks = 0;
    int c;
    logic [31:0] a;
    assign hready = hreadyout;
    initial forever #20 clk = ~clk;
    pbtc_top #(.NCH(10)) u_pbtc_top (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .block_enable(block_enable),
        .chan_request(chan_request), .block_end_signal(block_end_signal), .sys_req(sys_req),
        .sys_gnt(sys_gnt), .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready), .per_req(per_req),
        .per_gnt(per_gnt), .per_valid(per_valid), .per_write(per_write), .per_addr(per_addr),
        .per_wdata(per_wdata), .per_rdata(per_rdata), .per_ready(per_ready),
        .xfer_size(xfer_size));
    pbtc_partner u_pbtc_partner (.clk(clk), .srst(srst), .slow(slow), .sys_req(sys_req),
        .sys_gnt(sys_gnt), .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready), .per_req(per_req),
        .per_gnt(per_gnt), .per_valid(per_valid), .per_write(per_write), .per_addr(per_addr),
        .per_wdata(per_wdata), .per_rdata(per_rdata), .per_ready(per_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .n_done(n_done));
    // ----------------------------------------
    // monitors and tasks
    // ----------------------------------------
    always @(posedge clk)
    begin
        sreq_d <= sys_req;
        if (sys_req & !sreq_d)
            n_sreq <= n_sreq + 8'h01;
        if (|block_end_signal)
        begin
            n_end <= n_end + 8'h01;
            last_end <= block_end_signal;
        end
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task ahb(input logic w, input int ch, input logic [3:0] o, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ch[3:0], o};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task rdc(input int ch, input logic [3:0] o, input logic [31:0] e);
        ahb(1'b0, ch, o, 32'h0);
        chk(r, e);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task setup(input int ch, input logic [31:0] ctl, input logic [31:0] p, input logic [31:0] n);
        ahb(1'b1, ch, `PBTC_OFS_CTRL, ctl);
        ahb(1'b1, ch, `PBTC_OFS_PADDR, 32'hf0000000 + ch * 4);
        ahb(1'b1, ch, `PBTC_OFS_PTR, p);
        ahb(1'b1, ch, `PBTC_OFS_CNT, n);
    endtask
    task wait_done;
        n0 = n_done;
        while (n_done == n0) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    task elem(input logic [9:0] m);
        chan_request <= m;
        @(posedge clk);
        chan_request <= 10'h000;
        wait_done;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rdc(9, `PBTC_OFS_CTRL, 32'h0);
        ahb(1'b1, 0, `PBTC_OFS_CNT, 32'hffff1234);
        rdc(0, `PBTC_OFS_CNT, 32'h00001234);
        ahb(1'b1, 10, `PBTC_OFS_PTR, 32'h12345678);
        rdc(10, `PBTC_OFS_PTR, 32'h0);
        $display("register test done");
        for (int s = 0; s < 3; s++)
            for (int d = 0; d < 2; d++)
            begin
                c = s * 2 + d;
                a = 32'h00001000 * (c + 1);
                setup(c, {29'h0, s[1:0], d[0]}, a, 32'h2);
                for (int k = 0; k < 2; k++)
                begin
                    e0 = n_end;
                    elem(10'h001 << c);
                    chk(wr_addr, d ? 32'hf0000000 + c * 4 : a + (k << s));
                    if (s == 2)
                        chk(wr_data, d ? ~(a + (k << s)) ^ 32'h5a000000 : {c[13:0], 18'h03c00});
                    chk({24'h0, n_end - e0}, k);
                    chk({30'h0, xfer_size}, s);
                end
                chk({22'h0, last_end}, 32'h1 << c);
                rdc(c, `PBTC_OFS_PTR, a + (2 << s));
                rdc(c, `PBTC_OFS_CNT, 32'h0);
            end
        $display("size and direction test done");
        slow <= 1'b1;
        setup(8, 32'h4, 32'h8000, 32'h1);
        setup(9, 32'h4, 32'h9000, 32'h1);
        s0 = n_sreq;
        elem(10'h300);
        chk(wr_addr, 32'h8000);
        wait_done;
        chk(wr_addr, 32'h9000);
        chk({24'h0, n_sreq - s0}, 32'h2);
        $display("priority test done");
        n0 = n_done;
        chan_request <= 10'h100;
        @(posedge clk);
        chan_request <= 10'h000;
        repeat (12) @(posedge clk);
        chk({24'h0, n_done}, {24'h0, n0});
        rdc(8, `PBTC_OFS_PTR, 32'h8004);
        ahb(1'b1, 8, `PBTC_OFS_CNT, 32'h5);
        elem(10'h100);
        chk(wr_addr, 32'h8004);
        ahb(1'b1, 8, `PBTC_OFS_PTR, 32'ha000);
        ahb(1'b1, 8, `PBTC_OFS_CNT, 32'h3);
        elem(10'h100);
        chk(wr_addr, 32'ha000);
        rdc(8, `PBTC_OFS_PTR, 32'ha004);
        rdc(8, `PBTC_OFS_CNT, 32'h2);
        $display("stop and rewrite test done");
        block_enable <= 1'b0;
        n0 = n_done;
        chan_request <= 10'h100;
        @(posedge clk);
        chan_request <= 10'h000;
        repeat (12) @(posedge clk);
        chk({24'h0, n_done}, {24'h0, n0});
        block_enable <= 1'b1;
        wait_done;
        chk(wr_addr, 32'ha004);
        $display("enable test done");
        chan_request <= 10'h100;
        @(posedge clk);
        chan_request <= 10'h000;
        e0 = n_end;
        ahb(1'b1, 8, `PBTC_OFS_PTR, 32'hb000);
        ahb(1'b1, 8, `PBTC_OFS_CNT, 32'h4);
        wait_done;
        chk(wr_addr, 32'ha008);
        chk({24'h0, n_end - e0}, 32'h0);
        rdc(8, `PBTC_OFS_PTR, 32'hb000);
        rdc(8, `PBTC_OFS_CNT, 32'h4);
        $display("mid-block rewrite test done");
        print_verdict;
    end
endmodule
